// File: design/jac_pkg.sv
// shared constants and carriers for the jitter attenuator control block
package jac_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] RX_STATUS_ADDR = 8'h14;
  localparam logic [7:0] RX_REF_DIV_ADDR = 8'h15;
  localparam logic [7:0] RX_OUT_DIV_ADDR = 8'h16;
  localparam logic [7:0] RX_CONFIG_ADDR = 8'h17;
  localparam logic [7:0] TX_STATUS_ADDR = 8'h18;
  localparam logic [7:0] TX_REF_DIV_ADDR = 8'h19;
  localparam logic [7:0] TX_OUT_DIV_ADDR = 8'h1A;
  localparam logic [7:0] TX_CONFIG_ADDR = 8'h1B;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DIVIDER_RESET = 8'h2F;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int UNDERRUN_FLAG_BIT = 0;
  localparam int OVERRUN_FLAG_BIT = 1;
  localparam int SLEW_GUARD_BIT = 0;
  localparam int FIFO_RESET_ON_DIV_BIT = 1;
  localparam int OVERRUN_IRQ_EN_BIT = 2;
  localparam int UNDERRUN_IRQ_EN_BIT = 3;
  localparam int SELF_CENTER_BIT = 4;
  // ------------------------------------------------------------
  // counts in unit intervals
  // ------------------------------------------------------------
  localparam int CENTER_WINDOW_UI = 384;
  localparam int CENTER_MARGIN_UI = 4;
  localparam int SLEW_MARGIN_UI = 1;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr_en;
    logic wr_bit;
    logic rd_en;
  } jac_fifo_in_t;
  typedef struct packed {
    logic rd_bit;
    logic speed_up;
    logic slow_down;
    logic centering;
    logic ovr_evt;
    logic und_evt;
  } jac_chan_out_t;
endpackage

// File: design/jac_jat_chan.sv
// one jitter attenuator: bit fifo, self-centering, slew guard and loop dividers
`timescale 1ns/100ps
`default_nettype none
module jac_jat_chan #(
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ref_evt,
  input wire logic [7:0] cfg,
  input wire logic [7:0] ref_divider_value,
  input wire logic [7:0] out_divider_value,
  input wire logic loop_rst,
  input wire logic fifo_rst,
  input wire jac_pkg::jac_fifo_in_t fin,
  output jac_pkg::jac_chan_out_t fout
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CTR_LO = (AW+1)'(jac_pkg::CENTER_MARGIN_UI);
  localparam logic [AW:0] CTR_HI = (AW+1)'(DEPTH - jac_pkg::CENTER_MARGIN_UI);
  localparam logic [AW:0] SLEW_LO = (AW+1)'(jac_pkg::SLEW_MARGIN_UI);
  localparam logic [AW:0] SLEW_HI = (AW+1)'(DEPTH - jac_pkg::SLEW_MARGIN_UI);
  localparam logic [8:0] WINDOW = 9'(jac_pkg::CENTER_WINDOW_UI);

  if (DEPTH < 16 || DEPTH != (1 << AW)) begin : g_depth_check
    $error("depth must be a power of two, 16 or more");
  end

  logic [DEPTH-1:0] mem;
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic [AW:0] fill;
  logic [8:0] center_cnt;
  logic self_centering_enable_q;
  logic [7:0] ref_cnt, out_cnt;
  logic signed [7:0] phase;
  logic full, empty, self_centering_enable_on, push, pop, drop, ref_ph, out_ph;

  assign full = (fill == FULL_LVL);
  assign empty = (fill == '0);
  assign self_centering_enable_on = cfg[jac_pkg::SELF_CENTER_BIT] && (center_cnt != '0);
  // during centering the read pointer is held 4 UI clear of both ends; data is lost meanwhile
  assign pop = fin.rd_en && !empty && !(self_centering_enable_on && fill <= CTR_LO);
  assign drop = self_centering_enable_on && fin.wr_en && (fill >= CTR_HI) && !pop;
  // without centering a write into a full fifo is refused, stored data untouched
  assign push = fin.wr_en && (!full || drop);
  assign ref_ph = ref_evt && (ref_cnt == ref_divider_value);
  assign out_ph = fin.rd_en && (out_cnt == out_divider_value);

  // ------------------------------------------------------------
  // fifo storage and pointers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr] <= fin.wr_bit;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || fifo_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop || drop) rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop) - (AW+1)'(drop);
    end
  end

  // ------------------------------------------------------------
  // centering window, stretched while an alarm persists
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      self_centering_enable_q <= 1'b0;
      center_cnt <= '0;
    end else begin
      self_centering_enable_q <= cfg[jac_pkg::SELF_CENTER_BIT];
      if (!cfg[jac_pkg::SELF_CENTER_BIT]) begin
        center_cnt <= '0;
      end else if (!self_centering_enable_q || (fin.wr_en && full) || (fin.rd_en && empty)) begin
        center_cnt <= WINDOW;
      end else if (fin.rd_en && center_cnt != '0 && !full && !empty) begin
        center_cnt <= center_cnt - 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // loop dividers and phase discriminator
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || loop_rst) begin
      ref_cnt <= '0;
      out_cnt <= '0;
      phase <= '0;
    end else begin
      if (ref_evt) ref_cnt <= ref_ph ? 8'h00 : ref_cnt + 1'b1;
      if (fin.rd_en) out_cnt <= out_ph ? 8'h00 : out_cnt + 1'b1;
      if (ref_ph && !out_ph && phase != 8'sh7F) phase <= phase + 8'sh01;
      else if (out_ph && !ref_ph && phase != -8'sh80) phase <= phase - 8'sh01;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fout <= '0;
    end else begin
      if (pop) fout.rd_bit <= mem[rd_ptr];
      fout.ovr_evt <= fin.wr_en && full;
      fout.und_evt <= fin.rd_en && empty;
      fout.centering <= self_centering_enable_on;
      // guard overrides the loop near the fifo ends
      if (cfg[jac_pkg::SLEW_GUARD_BIT] && fill >= SLEW_HI) begin
        fout.speed_up <= 1'b1;
        fout.slow_down <= 1'b0;
      end else if (cfg[jac_pkg::SLEW_GUARD_BIT] && fill <= SLEW_LO) begin
        fout.speed_up <= 1'b0;
        fout.slow_down <= 1'b1;
      end else begin
        fout.speed_up <= (phase > 8'sh00);
        fout.slow_down <= (phase < 8'sh00);
      end
    end
  end
endmodule // jac_jat_chan
`default_nettype wire

// File: design/jac_top.sv
// register file, pin sampling and interrupt for both jitter attenuators
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module jac_top #(
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic recovered_clock_pin,
  input wire logic tx_clock_pin,
  input wire logic [3:0] tx_ref_clock_pins,
  input wire logic diag_loopback,
  input wire logic tx_ref_select_hi,
  input wire logic tx_ref_select_lo,
  input wire jac_pkg::jac_fifo_in_t rx_fifo_in,
  input wire jac_pkg::jac_fifo_in_t tx_fifo_in,
  output jac_pkg::jac_chan_out_t rx_out,
  output jac_pkg::jac_chan_out_t tx_out,
  output logic interrupt_out_n
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  // the channel pointers wrap by their bit width, so the depth must be
  // a power of two; below 16 the 4 UI centering margins and the 1 UI
  // slew margins would crowd each other and leave no working band;
  // a misfit depth is refused at elaboration rather than misbehaving later
  if (DEPTH < 16 || DEPTH != (1 << $clog2(DEPTH))) begin : g_depth_check
    $error("depth must be a power of two, 16 or more");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam int NPIN = 6;

  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_last;
  logic [NPIN-1:0] pin_rise;

  logic [7:0] rx_ref_divider_value;
  logic [7:0] rx_out_divider_value;
  logic [7:0] rx_config;
  logic [7:0] tx_ref_divider_value;
  logic [7:0] tx_out_divider_value;
  logic [7:0] tx_config;

  logic [1:0] rx_flags;
  logic [1:0] tx_flags;

  logic rx_loop_rst;
  logic rx_fifo_rst;
  logic tx_loop_rst;
  logic tx_fifo_rst;

  logic rx_ref_evt;
  logic tx_ref_evt;

  logic rx_div_wr;
  logic tx_div_wr;
  logic rx_stat_rd;
  logic tx_stat_rd;

  logic [7:0] next_rdata;
  logic [1:0] rx_irq_en;
  logic [1:0] tx_irq_en;
  logic irq_any;

  jac_pkg::jac_chan_out_t rx_chan;
  jac_pkg::jac_chan_out_t tx_chan;

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  // every clock pin is asynchronous to the system clock; the second
  // stage is the first one any logic may look at
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= {tx_ref_clock_pins, tx_clock_pin, recovered_clock_pin};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign pin_rise = pin_sync & ~pin_last;

  // ------------------------------------------------------------
  // reference selection
  // ------------------------------------------------------------
  // the pins are only sampled, so reference rates must stay well
  // below half the system clock for each edge to be seen
  always_comb begin
    rx_ref_evt = diag_loopback ? pin_rise[1] : pin_rise[0];
    case ({tx_ref_select_hi, tx_ref_select_lo})
      2'b00: tx_ref_evt = pin_rise[2];
      2'b01: tx_ref_evt = pin_rise[3];
      2'b10: tx_ref_evt = pin_rise[4];
      default: tx_ref_evt = pin_rise[5];
    endcase
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb begin
    rx_div_wr = 1'b0;
    tx_div_wr = 1'b0;
    if (reg_wr && (reg_addr == jac_pkg::RX_REF_DIV_ADDR)) begin
      rx_div_wr = 1'b1;
    end else if (reg_wr && (reg_addr == jac_pkg::RX_OUT_DIV_ADDR)) begin
      rx_div_wr = 1'b1;
    end else if (reg_wr && (reg_addr == jac_pkg::TX_REF_DIV_ADDR)) begin
      tx_div_wr = 1'b1;
    end else if (reg_wr && (reg_addr == jac_pkg::TX_OUT_DIV_ADDR)) begin
      tx_div_wr = 1'b1;
    end
  end

  assign rx_stat_rd = reg_rd && (reg_addr == jac_pkg::RX_STATUS_ADDR);
  assign tx_stat_rd = reg_rd && (reg_addr == jac_pkg::TX_STATUS_ADDR);

  // ------------------------------------------------------------
  // receive attenuator registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_ref_divider_value <= jac_pkg::DIVIDER_RESET;
      rx_out_divider_value <= jac_pkg::DIVIDER_RESET;
      rx_config <= jac_pkg::CONFIG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == jac_pkg::RX_REF_DIV_ADDR) begin
        rx_ref_divider_value <= reg_wdata;
      end else if (reg_addr == jac_pkg::RX_OUT_DIV_ADDR) begin
        rx_out_divider_value <= reg_wdata;
      end else if (reg_addr == jac_pkg::RX_CONFIG_ADDR) begin
        rx_config <= {3'h0, reg_wdata[4:0]};
      end
    end
  end

  // ------------------------------------------------------------
  // transmit attenuator registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_ref_divider_value <= jac_pkg::DIVIDER_RESET;
      tx_out_divider_value <= jac_pkg::DIVIDER_RESET;
      tx_config <= jac_pkg::CONFIG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == jac_pkg::TX_REF_DIV_ADDR) begin
        tx_ref_divider_value <= reg_wdata;
      end else if (reg_addr == jac_pkg::TX_OUT_DIV_ADDR) begin
        tx_out_divider_value <= reg_wdata;
      end else if (reg_addr == jac_pkg::TX_CONFIG_ADDR) begin
        tx_config <= {3'h0, reg_wdata[4:0]};
      end
    end
  end

  // ------------------------------------------------------------
  // loop and fifo resets from divider writes
  // ------------------------------------------------------------
  // the reset pulse lands one cycle after the write, together with
  // the new divider value, so the loop restarts on the new ratio
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_loop_rst <= 1'b0;
      rx_fifo_rst <= 1'b0;
      tx_loop_rst <= 1'b0;
      tx_fifo_rst <= 1'b0;
    end else begin
      rx_loop_rst <= rx_div_wr;
      rx_fifo_rst <= rx_div_wr && rx_config[jac_pkg::FIFO_RESET_ON_DIV_BIT];
      tx_loop_rst <= tx_div_wr;
      tx_fifo_rst <= tx_div_wr && tx_config[jac_pkg::FIFO_RESET_ON_DIV_BIT];
    end
  end

  // ------------------------------------------------------------
  // attenuator channels
  // ------------------------------------------------------------
  jac_jat_chan #(
    .DEPTH(DEPTH)
  ) u_rx_chan (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_evt(rx_ref_evt),
    .cfg(rx_config),
    .ref_divider_value(rx_ref_divider_value),
    .out_divider_value(rx_out_divider_value),
    .loop_rst(rx_loop_rst),
    .fifo_rst(rx_fifo_rst),
    .fin(rx_fifo_in),
    .fout(rx_chan)
  );

  jac_jat_chan #(
    .DEPTH(DEPTH)
  ) u_tx_chan (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_evt(tx_ref_evt),
    .cfg(tx_config),
    .ref_divider_value(tx_ref_divider_value),
    .out_divider_value(tx_out_divider_value),
    .loop_rst(tx_loop_rst),
    .fifo_rst(tx_fifo_rst),
    .fin(tx_fifo_in),
    .fout(tx_chan)
  );

  // the channel outputs are already flops; a second stage keeps the
  // top outputs registered at this level without reshaping them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_out <= '0;
      tx_out <= '0;
    end else begin
      rx_out <= rx_chan;
      tx_out <= tx_chan;
    end
  end

  // ------------------------------------------------------------
  // sticky event flags
  // ------------------------------------------------------------
  // an event in the same cycle as the clearing read stays set, so it
  // is reported by the next read instead of being lost
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_flags <= '0;
    end else begin
      rx_flags[jac_pkg::OVERRUN_FLAG_BIT] <= rx_chan.ovr_evt
        || (rx_flags[jac_pkg::OVERRUN_FLAG_BIT] && !rx_stat_rd);
      rx_flags[jac_pkg::UNDERRUN_FLAG_BIT] <= rx_chan.und_evt
        || (rx_flags[jac_pkg::UNDERRUN_FLAG_BIT] && !rx_stat_rd);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_flags <= '0;
    end else begin
      tx_flags[jac_pkg::OVERRUN_FLAG_BIT] <= tx_chan.ovr_evt
        || (tx_flags[jac_pkg::OVERRUN_FLAG_BIT] && !tx_stat_rd);
      tx_flags[jac_pkg::UNDERRUN_FLAG_BIT] <= tx_chan.und_evt
        || (tx_flags[jac_pkg::UNDERRUN_FLAG_BIT] && !tx_stat_rd);
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  always_comb begin
    rx_irq_en = '0;
    tx_irq_en = '0;
    rx_irq_en[jac_pkg::OVERRUN_FLAG_BIT] = rx_config[jac_pkg::OVERRUN_IRQ_EN_BIT];
    rx_irq_en[jac_pkg::UNDERRUN_FLAG_BIT] = rx_config[jac_pkg::UNDERRUN_IRQ_EN_BIT];
    tx_irq_en[jac_pkg::OVERRUN_FLAG_BIT] = tx_config[jac_pkg::OVERRUN_IRQ_EN_BIT];
    tx_irq_en[jac_pkg::UNDERRUN_FLAG_BIT] = tx_config[jac_pkg::UNDERRUN_IRQ_EN_BIT];
    irq_any = |(rx_flags & rx_irq_en) || |(tx_flags & tx_irq_en);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !irq_any;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == jac_pkg::RX_STATUS_ADDR) begin
      next_rdata = {6'h00, rx_flags};
    end else if (reg_addr == jac_pkg::RX_REF_DIV_ADDR) begin
      next_rdata = rx_ref_divider_value;
    end else if (reg_addr == jac_pkg::RX_OUT_DIV_ADDR) begin
      next_rdata = rx_out_divider_value;
    end else if (reg_addr == jac_pkg::RX_CONFIG_ADDR) begin
      next_rdata = rx_config;
    end else if (reg_addr == jac_pkg::TX_STATUS_ADDR) begin
      next_rdata = {6'h00, tx_flags};
    end else if (reg_addr == jac_pkg::TX_REF_DIV_ADDR) begin
      next_rdata = tx_ref_divider_value;
    end else if (reg_addr == jac_pkg::TX_OUT_DIV_ADDR) begin
      next_rdata = tx_out_divider_value;
    end else if (reg_addr == jac_pkg::TX_CONFIG_ADDR) begin
      next_rdata = tx_config;
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // jac_top
`default_nettype wire

// File: dv/jac_top_assertions.sv
// assertion checker bound to the jitter attenuator control top
`timescale 1ns/100ps
`default_nettype none
module jac_top_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire jac_pkg::jac_chan_out_t rx_out,
  input wire jac_pkg::jac_chan_out_t tx_out,
  input wire logic interrupt_out_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // shadow of the interrupt enables {underrun, overrun}
  // ------------------------------------------------------------
  logic [1:0] rx_en;
  logic [1:0] tx_en;
  logic rd_rx;
  logic rd_tx;
  assign rd_rx = reg_rd && reg_addr == jac_pkg::RX_STATUS_ADDR;
  assign rd_tx = reg_rd && reg_addr == jac_pkg::TX_STATUS_ADDR;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_en <= 2'h0;
      tx_en <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == jac_pkg::RX_CONFIG_ADDR) rx_en <= reg_wdata[3:2];
      if (reg_addr == jac_pkg::TX_CONFIG_ADDR) tx_en <= reg_wdata[3:2];
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_rx_ovr_irq;
    rx_out.ovr_evt && rx_en[0] |=> !interrupt_out_n;
  endproperty
  property p_rx_und_irq;
    rx_out.und_evt && rx_en[1] |=> !interrupt_out_n;
  endproperty
  property p_tx_ovr_irq;
    tx_out.ovr_evt && tx_en[0] |=> !interrupt_out_n;
  endproperty
  property p_tx_und_irq;
    tx_out.und_evt && tx_en[1] |=> !interrupt_out_n;
  endproperty
  property p_irq_quiet;
    (rx_en == 2'h0 && tx_en == 2'h0) [*2] |-> interrupt_out_n;
  endproperty
  // flags only drop on a status read and enables only change on a write, so the line must hold otherwise
  property p_irq_holds;
    !interrupt_out_n && !rd_rx && !rd_tx && !reg_wr && !$past(rd_rx) && !$past(rd_tx)
      && !$past(reg_wr) |=> !interrupt_out_n;
  endproperty
  property p_rx_clear;
    rd_rx ##1 (rd_rx && !rx_out.ovr_evt && !rx_out.und_evt) |=> reg_rdata == 8'h00;
  endproperty
  property p_tx_clear;
    rd_tx ##1 (rd_tx && !tx_out.ovr_evt && !tx_out.und_evt) |=> reg_rdata == 8'h00;
  endproperty
  property p_status_hi;
    rd_rx || rd_tx |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_rx_ovr_irq: assert property (p_rx_ovr_irq) else $error("rx overrun irq missing");
  a_rx_und_irq: assert property (p_rx_und_irq) else $error("rx underrun irq missing");
  a_tx_ovr_irq: assert property (p_tx_ovr_irq) else $error("tx overrun irq missing");
  a_tx_und_irq: assert property (p_tx_und_irq) else $error("tx underrun irq missing");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no enables");
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped without read");
  a_rx_clear: assert property (p_rx_clear) else $error("rx status not cleared");
  a_tx_clear: assert property (p_tx_clear) else $error("tx status not cleared");
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  c_rx_ovr: cover property (rx_out.ovr_evt);
  c_rx_und: cover property (rx_out.und_evt);
  c_tx_ovr: cover property (tx_out.ovr_evt);
  c_irq: cover property (!interrupt_out_n);
endmodule // jac_top_chk
bind jac_top jac_top_chk i_jac_top_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_out(rx_out), .tx_out(tx_out), .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// File: dv/jac_far_model.sv
// far-side model: framer data path feeding both fifos, plus the line clocks
`timescale 1ns/100ps
`default_nettype none
module jac_far_model (
  input wire logic clock,
  output var jac_pkg::jac_fifo_in_t rx_fifo_in,
  output var jac_pkg::jac_fifo_in_t tx_fifo_in,
  output var logic recovered_clock_pin,
  output var logic tx_clock_pin,
  output var logic [3:0] tx_ref_clock_pins
);
  logic [3:0] ph;
  initial begin
    rx_fifo_in = '0;
    tx_fifo_in = '0;
    ph = 4'h0;
  end
  // line clocks run free; well below the system clock so every edge is seen
  always @(posedge clock) begin
    ph <= ph + 4'h1;
    recovered_clock_pin <= ph[3];
    tx_clock_pin <= ph[2];
    tx_ref_clock_pins <= {ph[3], ph[2], ph[3], ph[2]};
  end
  // n one-cycle writes (rd=0) or bit reads (rd=1) into one fifo
  task automatic move(input bit tx, input bit rd, input int n);
    jac_pkg::jac_fifo_in_t v;
    for (int i = 0; i < n; i++) begin
      v.wr_en = !rd;
      v.wr_bit = i[0];
      v.rd_en = rd;
      @(posedge clock);
      if (tx) tx_fifo_in <= v;
      else rx_fifo_in <= v;
    end
    @(posedge clock);
    rx_fifo_in <= '0;
    tx_fifo_in <= '0;
  endtask
endmodule // jac_far_model
`default_nettype wire

// File: dv/jac_tb_top.sv
// self-checking testbench for the jitter attenuator control block
`timescale 1ns/100ps
`default_nettype none
module jac_tb_top;
  localparam int DEPTH = 16;
  localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h2F, 8'h2F, 8'h01, 8'h00, 8'h2F, 8'h2F, 8'h01};
  logic clock;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rec_clk;
  logic tx_clk;
  logic [3:0] ref_clks;
  logic diag_loopback;
  logic sel_hi;
  logic sel_lo;
  jac_pkg::jac_fifo_in_t rx_fifo_in;
  jac_pkg::jac_fifo_in_t tx_fifo_in;
  jac_pkg::jac_chan_out_t rx_out;
  jac_pkg::jac_chan_out_t tx_out;
  logic interrupt_out_n;
  int err_count;
  int checked;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  jac_top #(.DEPTH(DEPTH)) i_jac_top (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .recovered_clock_pin(rec_clk), .tx_clock_pin(tx_clk), .tx_ref_clock_pins(ref_clks),
    .diag_loopback(diag_loopback), .tx_ref_select_hi(sel_hi), .tx_ref_select_lo(sel_lo),
    .rx_fifo_in(rx_fifo_in), .tx_fifo_in(tx_fifo_in), .rx_out(rx_out), .tx_out(tx_out),
    .interrupt_out_n(interrupt_out_n));
  jac_far_model i_jac_far_model (.clock(clock), .rx_fifo_in(rx_fifo_in),
    .tx_fifo_in(tx_fifo_in), .recovered_clock_pin(rec_clk), .tx_clock_pin(tx_clk),
    .tx_ref_clock_pins(ref_clks));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %0t output level %b expected %b", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, e);
  endtask
  // two back-to-back reads of one address, strobe held across both
  task automatic rd2(input logic [7:0] a, input logic [7:0] e1, input logic [7:0] e2);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    #1 chk8(reg_rdata, e1);
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, e2);
  endtask
  // bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (interrupt_out_n !== lvl && n < 40) begin
      @(posedge clock);
      n++;
    end
    #1 chk1(interrupt_out_n, lvl);
    if (interrupt_out_n !== lvl) test_done();
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    diag_loopback = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'h14 + i[7:0], RST_VAL[i]);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(jac_pkg::RX_REF_DIV_ADDR, 8'hFF);
    wr(jac_pkg::RX_OUT_DIV_ADDR, 8'hFF);
    rd(jac_pkg::RX_REF_DIV_ADDR, 8'hFF);
    rd(jac_pkg::RX_OUT_DIV_ADDR, 8'hFF);
    diag_loopback <= 1'b1;
    sel_lo <= 1'b1;
    wr(jac_pkg::TX_REF_DIV_ADDR, 8'hC0);
    wr(jac_pkg::TX_OUT_DIV_ADDR, 8'hC0);
    rd(jac_pkg::TX_REF_DIV_ADDR, 8'hC0);
    rd(jac_pkg::TX_OUT_DIV_ADDR, 8'hC0);
    wr(jac_pkg::TX_REF_DIV_ADDR, 8'h00);
    rd(jac_pkg::TX_REF_DIV_ADDR, 8'h00);
    wr(jac_pkg::TX_REF_DIV_ADDR, 8'h01);
    rd(jac_pkg::TX_REF_DIV_ADDR, 8'h01);
    // underrun on the empty tx fifo with interrupts masked
    i_jac_far_model.move(1'b1, 1'b1, 1);
    repeat (4) @(posedge clock);
    #1 chk1(interrupt_out_n, 1'b1);
    rd2(jac_pkg::TX_STATUS_ADDR, 8'h01, 8'h00);
    // rx overrun with its enable and slew guard set
    wr(jac_pkg::RX_CONFIG_ADDR, 8'h05);
    i_jac_far_model.move(1'b0, 1'b0, DEPTH + 1);
    wait_irq(1'b0);
    chk1(rx_out.speed_up, 1'b1);
    rd2(jac_pkg::RX_STATUS_ADDR, 8'h02, 8'h00);
    wait_irq(1'b1);
    // divider write without fifo reset: fifo stays full
    wr(jac_pkg::RX_REF_DIV_ADDR, 8'hFF);
    repeat (4) @(posedge clock);
    i_jac_far_model.move(1'b0, 1'b0, 1);
    wait_irq(1'b0);
    rd(jac_pkg::RX_STATUS_ADDR, 8'h02);
    // divider write with fifo reset: next read underruns
    wr(jac_pkg::RX_CONFIG_ADDR, 8'h0F);
    wr(jac_pkg::RX_OUT_DIV_ADDR, 8'hFF);
    repeat (4) @(posedge clock);
    i_jac_far_model.move(1'b0, 1'b1, 1);
    wait_irq(1'b0);
    rd(jac_pkg::RX_STATUS_ADDR, 8'h01);
    chk1(rx_out.slow_down, 1'b1);
    wait_irq(1'b1);
    // tx overrun through the shared line
    wr(jac_pkg::TX_CONFIG_ADDR, 8'h04);
    i_jac_far_model.move(1'b1, 1'b0, DEPTH + 1);
    wait_irq(1'b0);
    rd(jac_pkg::TX_STATUS_ADDR, 8'h02);
    i_jac_far_model.move(1'b1, 1'b1, 2);
    repeat (2) @(posedge clock);
    #1 chk1(tx_out.rd_bit, 1'b1);
    wr(jac_pkg::RX_CONFIG_ADDR, 8'h10);
    repeat (4) @(posedge clock);
    #1 chk1(rx_out.centering, 1'b1);
    test_done();
  end
endmodule // jac_tb_top
`default_nettype wire
